// File: logic/skip_call_pkg.sv
package skip_call_pkg;
    localparam int PC_W = 10;
    localparam int DATA_W = 8;
    localparam int REG_ADDR_W = 6;
    localparam int BIT_SEL_W = 3;
    localparam int STACK_PTR_W = 3;
    localparam int STACK_DEPTH = 8;
    localparam logic [PC_W-1:0] PC_RESET = 10'h000;
    localparam logic [STACK_PTR_W-1:0] SP_RESET = 3'h0;
    localparam logic [PC_W-1:0] PC_STEP = 10'h001;
    localparam logic [STACK_PTR_W-1:0] SP_STEP = 3'h1;
    localparam logic [1:0] HIGH_BITS_LSB = 2'h0;

    typedef enum logic [1:0] {
        OP_NONE,
        OP_TEST_CLEAR,
        OP_TEST_SET,
        OP_CALL
    } unit_op_e;
endpackage

// File: logic/return_stack.sv
`timescale 1ns/10ps
module return_stack
    import skip_call_pkg::*;
#(
    parameter int DEPTH = STACK_DEPTH
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic push_i,
    input wire logic [PC_W-1:0] push_data_i,
    output logic [STACK_PTR_W-1:0] ptr_o,
    output logic [PC_W-1:0] top_o
);
    logic [PC_W-1:0] slot_mem [DEPTH];
    logic [STACK_PTR_W-1:0] ptr_reg;
    logic [PC_W-1:0] top_reg;

    assign ptr_o = ptr_reg;
    assign top_o = top_reg;

    // Store at current slot, then advance
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ptr_reg <= SP_RESET;
            top_reg <= PC_RESET;
        end else if (push_i) begin
            ptr_reg <= ptr_reg + SP_STEP;
            top_reg <= push_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (push_i) begin
            slot_mem[ptr_reg] <= push_data_i;
        end
    end

    property p_slot_write;
        @(posedge clk_i) disable iff (!rst_b_i)
        push_i |=> slot_mem[$past(ptr_reg)] == $past(push_data_i) && top_reg == $past(push_data_i);
    endproperty
    a_slot_write: assert property (p_slot_write) else $error("push not stored at pointer slot");
endmodule

// File: logic/bit_test_skip_and_call_unit.sv
// Functional notes
// - Skip-if-clear skips when bit is 0
// - Skip-if-set skips when bit is 1
// - Skip runs NOP instead; 1 or 2 cycles
// - Calls push PC plus one first
// - Immediate call: two cycles, immediate to PC low
// - Immediate call: buffer bits 1:0 to PC high
// - Register call: two cycles, pointer to PC high
// - Register call: working register to PC low
`timescale 1ns/10ps
module bit_test_skip_and_call_unit
    import skip_call_pkg::*;
(
    // Clock and reset
    input wire logic CORE_CLK_I,
    input wire logic RST_B_I,
    // Decoded instruction strobes (one cycle each)
    input wire logic TEST_BIT_SKIP_IF_CLEAR_I,
    input wire logic TEST_BIT_SKIP_IF_SET_I,
    input wire logic CALL_IMMEDIATE_I,
    input wire logic CALL_VIA_WORKING_REGISTER_I,
    input wire logic [BIT_SEL_W-1:0] BIT_SEL_I,
    input wire logic [DATA_W-1:0] IMMEDIATE_I,
    input wire logic [PC_W-1:0] CURRENT_PC_I,
    // Operand sources
    input wire logic [DATA_W-1:0] REG_DATA_I,
    input wire logic [DATA_W-1:0] WORKING_REGISTER_I,
    input wire logic [DATA_W-1:0] PROGRAM_COUNTER_HIGH_BUFFER_I,
    input wire logic [DATA_W-1:0] TABLE_HIGH_POINTER_I,
    // Fetch stage control
    output logic DISCARD_NEXT_O,
    output logic PC_LOAD_O,
    output logic [PC_W-1:0] PC_TARGET_O,
    output logic BUSY_O,
    // Stack view
    output logic [STACK_PTR_W-1:0] STACK_PTR_O,
    output logic [PC_W-1:0] STACK_TOP_O
);
    // ==========================================
    // Decode
    // ==========================================
    function automatic logic bit_of(input logic [DATA_W-1:0] d, input logic [BIT_SEL_W-1:0] s);
        return d[s];
    endfunction

    logic busy_reg;
    logic discard_reg;
    logic pc_load_reg;
    logic [PC_W-1:0] pc_target_reg;

    wire logic idle = !busy_reg;
    wire logic sel_bit = bit_of(REG_DATA_I, BIT_SEL_I);
    wire logic skip_clear = idle && TEST_BIT_SKIP_IF_CLEAR_I && !sel_bit;
    wire logic skip_set = idle && TEST_BIT_SKIP_IF_SET_I && sel_bit;
    wire logic skip_go = skip_clear || skip_set;
    wire logic call_imm = idle && CALL_IMMEDIATE_I;
    wire logic call_wreg = idle && !CALL_IMMEDIATE_I && CALL_VIA_WORKING_REGISTER_I;
    wire logic call_go = call_imm || call_wreg;
    wire logic [PC_W-1:0] return_addr = CURRENT_PC_I + PC_STEP;
    wire logic [PC_W-1:0] target_imm = {PROGRAM_COUNTER_HIGH_BUFFER_I[HIGH_BITS_LSB +: 2], IMMEDIATE_I};
    wire logic [PC_W-1:0] target_wreg = {TABLE_HIGH_POINTER_I[HIGH_BITS_LSB +: 2], WORKING_REGISTER_I};
    wire logic [PC_W-1:0] target_next = call_imm ? target_imm : target_wreg;

    // ==========================================
    // Sequencing: second cycle of skip or call
    // ==========================================
    always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            busy_reg <= 1'h0;
            discard_reg <= 1'h0;
            pc_load_reg <= 1'h0;
            pc_target_reg <= PC_RESET;
        end else begin
            busy_reg <= skip_go || call_go;
            discard_reg <= skip_go;
            pc_load_reg <= call_go;
            if (call_go) begin
                pc_target_reg <= target_next;
            end
        end
    end

    assign DISCARD_NEXT_O = discard_reg;
    assign PC_LOAD_O = pc_load_reg;
    assign PC_TARGET_O = pc_target_reg;
    assign BUSY_O = busy_reg;

    // ==========================================
    // Hardware stack
    // ==========================================
    return_stack #(
        .DEPTH(STACK_DEPTH)
    ) u_stack (
        .clk_i(CORE_CLK_I),
        .rst_b_i(RST_B_I),
        .push_i(call_go),
        .push_data_i(return_addr),
        .ptr_o(STACK_PTR_O),
        .top_o(STACK_TOP_O)
    );

    // ==========================================
    // Checks
    // ==========================================
    property p_skip_clear;
        @(posedge CORE_CLK_I) disable iff (!RST_B_I)
        skip_clear |=> DISCARD_NEXT_O && BUSY_O;
    endproperty
    a_skip_clear: assert property (p_skip_clear) else $error("clear skip missed");

    property p_skip_set;
        @(posedge CORE_CLK_I) disable iff (!RST_B_I)
        skip_set |=> DISCARD_NEXT_O;
    endproperty
    a_skip_set: assert property (p_skip_set) else $error("set skip missed");

    property p_no_skip;
        @(posedge CORE_CLK_I) disable iff (!RST_B_I)
        (idle && (TEST_BIT_SKIP_IF_CLEAR_I || TEST_BIT_SKIP_IF_SET_I) && !skip_go && !call_go) |=> !BUSY_O;
    endproperty
    a_no_skip: assert property (p_no_skip) else $error("non-skip test took two cycles");

    property p_discard_one;
        @(posedge CORE_CLK_I) disable iff (!RST_B_I)
        DISCARD_NEXT_O |=> !DISCARD_NEXT_O;
    endproperty
    a_discard_one: assert property (p_discard_one) else $error("discard held too long");

    property p_push_addr;
        @(posedge CORE_CLK_I) disable iff (!RST_B_I)
        call_go |=> STACK_TOP_O == $past(CURRENT_PC_I) + PC_STEP;
    endproperty
    a_push_addr: assert property (p_push_addr) else $error("wrong return address");

    property p_call_imm;
        @(posedge CORE_CLK_I) disable iff (!RST_B_I)
        call_imm |=> PC_LOAD_O && PC_TARGET_O == {$past(PROGRAM_COUNTER_HIGH_BUFFER_I[1:0]), $past(IMMEDIATE_I)};
    endproperty
    a_call_imm: assert property (p_call_imm) else $error("immediate call target wrong");

    property p_call_wreg;
        @(posedge CORE_CLK_I) disable iff (!RST_B_I)
        call_wreg |=> PC_LOAD_O && PC_TARGET_O == {$past(TABLE_HIGH_POINTER_I[1:0]), $past(WORKING_REGISTER_I)};
    endproperty
    a_call_wreg: assert property (p_call_wreg) else $error("register call target wrong");

    property p_call_two;
        @(posedge CORE_CLK_I) disable iff (!RST_B_I)
        call_go |=> BUSY_O ##1 !BUSY_O;
    endproperty
    a_call_two: assert property (p_call_two) else $error("call not two cycles");

    property p_sp_inc;
        @(posedge CORE_CLK_I) disable iff (!RST_B_I)
        call_go |=> STACK_PTR_O == $past(STACK_PTR_O) + SP_STEP;
    endproperty
    a_sp_inc: assert property (p_sp_inc) else $error("stack pointer not advanced");

    property p_busy_one;
        @(posedge CORE_CLK_I) disable iff (!RST_B_I)
        BUSY_O |=> !BUSY_O;
    endproperty
    a_busy_one: assert property (p_busy_one) else $error("busy held too long");

    property p_skip_no_load;
        @(posedge CORE_CLK_I) disable iff (!RST_B_I)
        (skip_go && !call_go) |=> !PC_LOAD_O;
    endproperty
    a_skip_no_load: assert property (p_skip_no_load) else $error("skip loaded the counter");

    property p_skip_no_push;
        @(posedge CORE_CLK_I) disable iff (!RST_B_I)
        (skip_go && !call_go) |=> $stable(STACK_PTR_O);
    endproperty
    a_skip_no_push: assert property (p_skip_no_push) else $error("skip pushed the stack");

    property p_clear_keep;
        @(posedge CORE_CLK_I) disable iff (!RST_B_I)
        (idle && TEST_BIT_SKIP_IF_CLEAR_I && !TEST_BIT_SKIP_IF_SET_I && REG_DATA_I[BIT_SEL_I]) |=> !DISCARD_NEXT_O;
    endproperty
    a_clear_keep: assert property (p_clear_keep) else $error("clear test skipped on set bit");

    property p_set_keep;
        @(posedge CORE_CLK_I) disable iff (!RST_B_I)
        (idle && TEST_BIT_SKIP_IF_SET_I && !TEST_BIT_SKIP_IF_CLEAR_I && !REG_DATA_I[BIT_SEL_I]) |=> !DISCARD_NEXT_O;
    endproperty
    a_set_keep: assert property (p_set_keep) else $error("set test skipped on clear bit");

    property p_busy_refuse;
        @(posedge CORE_CLK_I) disable iff (!RST_B_I)
        BUSY_O |=> $stable(STACK_PTR_O) && !PC_LOAD_O;
    endproperty
    a_busy_refuse: assert property (p_busy_refuse) else $error("strobe taken while busy");

    property p_target_hold;
        @(posedge CORE_CLK_I) disable iff (!RST_B_I)
        !call_go |=> $stable(PC_TARGET_O);
    endproperty
    a_target_hold: assert property (p_target_hold) else $error("target moved without a call");

    property p_top_hold;
        @(posedge CORE_CLK_I) disable iff (!RST_B_I)
        !call_go |=> $stable(STACK_TOP_O);
    endproperty
    a_top_hold: assert property (p_top_hold) else $error("stack top moved without a call");

    property p_call_no_discard;
        @(posedge CORE_CLK_I) disable iff (!RST_B_I)
        (call_go && !skip_go) |=> !DISCARD_NEXT_O;
    endproperty
    a_call_no_discard: assert property (p_call_no_discard) else $error("call raised discard");

    property p_imm_priority;
        @(posedge CORE_CLK_I) disable iff (!RST_B_I)
        (idle && CALL_IMMEDIATE_I && CALL_VIA_WORKING_REGISTER_I) |=> PC_TARGET_O[7:0] == $past(IMMEDIATE_I);
    endproperty
    a_imm_priority: assert property (p_imm_priority) else $error("immediate call lost priority");

    property p_load_one;
        @(posedge CORE_CLK_I) disable iff (!RST_B_I)
        PC_LOAD_O |=> !PC_LOAD_O;
    endproperty
    a_load_one: assert property (p_load_one) else $error("load held too long");
endmodule

// File: tb/bit_test_skip_and_call_unit_tb_top.sv
`timescale 1ns/10ps
module bit_test_skip_and_call_unit_tb_top;
    import skip_call_pkg::*;
    // ====================
    // Stimulus and wiring
    logic clk = 1'h0;
    logic rst_b = 1'h0;
    logic [3:0] strb = 4'h0;
    logic [2:0] bsel = 3'h0;
    logic [7:0] imm = 8'h00;
    logic [7:0] rdat = 8'h00;
    logic [7:0] wreg = 8'h00;
    logic [7:0] pchb = 8'h00;
    logic [7:0] table_high_pointer = 8'h00;
    logic [9:0] pc = 10'h000;
    logic disc, load, busy;
    logic [9:0] tgt, top;
    logic [2:0] sp, sp0;
    int fails = 0;
    int compares = 0;
    int cycles = 0;
    always #4 clk = ~clk;
    bit_test_skip_and_call_unit uut (.CORE_CLK_I(clk), .RST_B_I(rst_b),
        .TEST_BIT_SKIP_IF_CLEAR_I(strb[0]), .TEST_BIT_SKIP_IF_SET_I(strb[1]),
        .CALL_IMMEDIATE_I(strb[2]), .CALL_VIA_WORKING_REGISTER_I(strb[3]),
        .BIT_SEL_I(bsel), .IMMEDIATE_I(imm), .CURRENT_PC_I(pc), .REG_DATA_I(rdat),
        .WORKING_REGISTER_I(wreg), .PROGRAM_COUNTER_HIGH_BUFFER_I(pchb),
        .TABLE_HIGH_POINTER_I(table_high_pointer), .DISCARD_NEXT_O(disc), .PC_LOAD_O(load),
        .PC_TARGET_O(tgt), .BUSY_O(busy), .STACK_PTR_O(sp), .STACK_TOP_O(top));
    // ====================
    // Checking helpers
    task automatic finish_test();
        if (fails == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [9:0] seen, input logic [9:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("FAIL %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic issue(input logic [3:0] s);
        strb = s;
        @(negedge clk);
        strb = 4'h0;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            finish_test();
        end
    end
    // ====================
    // Scenarios
    task automatic test_skip();
        logic e;
        for (int o = 0; o < 2; o++) begin
            for (int b = 0; b < 8; b++) begin
                for (int v = 0; v < 2; v++) begin
                    bsel = b[2:0];
                    rdat = v[0] ? (8'h01 << b) : ~(8'h01 << b);
                    e = (o == 0) ? (v == 0) : (v == 1);
                    issue(o[0] ? 4'h2 : 4'h1);
                    chk("discard", {9'h000, disc}, {9'h000, e});
                    chk("busy", {9'h000, busy}, {9'h000, e});
                    chk("load", {9'h000, load}, 10'h000);
                    @(negedge clk);
                    chk("discard_end", {9'h000, disc}, 10'h000);
                end
            end
        end
    endtask
    task automatic test_call_imm();
        for (int i = 0; i < 9; i++) begin
            pc = 10'h0A0 + i[9:0];
            imm = 8'h34 + i[7:0];
            pchb = 8'hFE;
            sp0 = sp;
            issue(4'h4);
            chk("load", {9'h000, load}, 10'h001);
            chk("busy", {9'h000, busy}, 10'h001);
            chk("target", tgt, {2'h2, imm});
            chk("top", top, pc + 10'h001);
            chk("ptr", {7'h00, sp}, {7'h00, sp0 + 3'h1});
            @(negedge clk);
            chk("load_end", {9'h000, load}, 10'h000);
        end
    endtask
    task automatic test_call_wr();
        pc = 10'h1C7;
        wreg = 8'hA5;
        table_high_pointer = 8'hFD;
        pchb = 8'h03;
        sp0 = sp;
        issue(4'h8);
        chk("load", {9'h000, load}, 10'h001);
        chk("target", tgt, 10'h1A5);
        chk("top", top, 10'h1C8);
        chk("ptr", {7'h00, sp}, {7'h00, sp0 + 3'h1});
        @(negedge clk);
        chk("busy_end", {9'h000, busy}, 10'h000);
    endtask
    task automatic test_refuse();
        strb = 4'h4;
        @(negedge clk);
        chk("first_load", {9'h000, load}, 10'h001);
        sp0 = sp;
        strb = 4'h8;
        @(negedge clk);
        strb = 4'h0;
        chk("refused_load", {9'h000, load}, 10'h000);
        chk("refused_ptr", {7'h00, sp}, {7'h00, sp0});
        chk("refused_target", tgt, {2'h3, imm});
        @(negedge clk);
    endtask
    task automatic test_priority();
        imm = 8'h5B;
        pchb = 8'h01;
        wreg = 8'hC3;
        table_high_pointer = 8'h02;
        issue(4'hC);
        chk("prio_target", tgt, 10'h15B);
        @(negedge clk);
        chk("prio_busy_end", {9'h000, busy}, 10'h000);
    endtask
    task automatic chk_cleared();
        chk("reset_disc", {9'h000, disc}, 10'h000);
        chk("reset_load", {9'h000, load}, 10'h000);
        chk("reset_busy", {9'h000, busy}, 10'h000);
        chk("reset_target", tgt, 10'h000);
        chk("reset_top", top, 10'h000);
        chk("reset_ptr", {7'h00, sp}, 10'h000);
    endtask
    task automatic test_reset();
        rst_b = 1'h0;
        @(negedge clk);
        chk_cleared();
        rst_b = 1'h1;
        pc = 10'h2FF;
        imm = 8'h12;
        pchb = 8'h03;
        issue(4'h4);
        chk("after_reset_target", tgt, 10'h312);
        chk("after_reset_top", top, 10'h300);
        chk("after_reset_ptr", {7'h00, sp}, 10'h001);
        @(negedge clk);
    endtask
    initial begin
        repeat (10) @(negedge clk);
        chk_cleared();
        rst_b = 1'h1;
        test_skip();
        test_call_imm();
        test_call_wr();
        test_refuse();
        test_priority();
        test_reset();
        finish_test();
    end
endmodule
